/* File: inc/pdr_consts.svh */
`ifndef PDR_CONSTS_SVH
`define PDR_CONSTS_SVH

// register indices; byte address is four times the index
`define PDR_IDX_TEN 6'h1a
`define PDR_IDX_BIST1 6'h1b
`define PDR_IDX_BIST2 6'h1c
`define PDR_IDX_DIAG 6'h1e
`define PDR_IDX_RST 6'h1f
`define PDR_IDX_INTST 6'h20
`define PDR_IDX_INTMSK 6'h21

// ten_mbit_ctrl_status fields
`define PDR_TEN_LOWTH 13
`define PDR_TEN_SQ_HI 12
`define PDR_TEN_SQ_LO 9
`define PDR_TEN_NLP 7
`define PDR_TEN_POL 4
`define PDR_TEN_JAB 0
`define PDR_TEN_RW_MASK 16'h3e81
`define PDR_SQ_RESET 4'h0

// selftest_errcount_gap / selftest_packet_length fields
`define PDR_B1_ERR_HI 15
`define PDR_B1_ERR_LO 8
`define PDR_B1_LOCKCLR 15
`define PDR_B1_IPG_HI 7
`define PDR_IPG_RESET 8'h7d
`define PDR_B2_LEN_HI 10
`define PDR_PKTLEN_RESET 11'h5dc
`define PDR_ERR_MAX 8'hff

// cable_diag_control fields
`define PDR_DG_START 15
`define PDR_DG_LQ_HI 9
`define PDR_DG_LQ_LO 8
`define PDR_DG_DONE 1
`define PDR_DG_FAIL 0
`define PDR_LQ_NONE 2'h0

// phy_reset_control fields
`define PDR_RC_SWRST 15
`define PDR_RC_RESTART 14

// interrupt status / mask layout
`define PDR_INT_W 4
`define PDR_INT_DONE 0
`define PDR_INT_FAIL 1
`define PDR_INT_POL 2
`define PDR_INT_SAT 3

`endif

/* File: inc/pdr_pkg.sv */
package pdr_pkg;

    // controls driven toward the phy circuitry
    typedef struct packed {
        logic lowerRxThresholdEn;
        logic [3:0] squelchLevel;
        logic linkPulseTxOff;
        logic jabberOff;
        logic [7:0] ipgLength;
        logic [10:0] packetLength;
        logic diagStart;
        logic phySoftReset;
        logic phyRestart;
    } pdr_ctrl_t;

    // events and status coming from the phy circuitry
    typedef struct packed {
        logic polarityInv;
        logic bistByteErr;
        logic bistCountMode;
        logic diagDone;
        logic diagFail;
        logic [1:0] linkQuality;
        logic linkUp;
    } pdr_evt_t;

endpackage : pdr_pkg

/* File: core/pdr_regs.sv */
`include "pdr_consts.svh"

// Summary of operation
// [R01] reserved bits read zero and ignore writes
// [R02] bit 13 selects lower 10 Mb/s receive threshold, reset 0
// [R03] bits 12:9 set squelch threshold, 50mV steps, reset 0 = 200mV
// [R04] bit 7 set stops link pulses, clear allows them
// [R05] polarity flag mirrors status bit 4, cleared by reading this register
// [R06] bit 0 set disables jabber protection, 10 Mb/s only
// [R07] bits 15:8 count self-test byte errors, saturate at 0xFF in mode 0
// [R08] any write freezes error count; bit 15 also clears running counter
// [R09] bits 7:0 give inter-packet gap bytes, reset 0x7D
// [R10] bits 10:0 give generated packet length, reset 0x5DC
// [R11] software sets start bit, device clears it when done rises
// [R12] done and fail bits read-only, reset zero
// [R13] bits 9:8 report link quality, valid only while link is up
// [R14] bit 15 resets whole phy like hardware reset, then clears
// [R15] bit 14 restarts phy circuitry keeping registers, then clears
// [R16] after software reset all fields return to defaults
module pdr_regs #(
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // phy side
    input wire pdr_pkg::pdr_evt_t phyEvt,
    output pdr_pkg::pdr_ctrl_t phyCtrl,
    output logic polarityMirror,
    output logic irq
);
    import pdr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    logic [ADDR_W-3:0] regIdx;
    logic access;
    logic wr;
    logic rd;
    logic wrTen;
    logic rdTen;
    logic wrBist1;
    logic wrBist2;
    logic wrDiag;
    logic wrRst;
    logic wrIntSt;
    logic wrIntMsk;
    logic rstAll;

    logic lowerRxTh;
    logic [3:0] squelch;
    logic nlpOff;
    logic jabOff;
    logic polarity;
    logic [7:0] errCnt;
    logic [7:0] next_errCnt;
    logic [7:0] errLatch;
    logic [7:0] ipgLen;
    logic [10:0] pktLen;
    logic diagStart;
    logic diagDoneBit;
    logic diagFailBit;
    logic swReset;
    logic restart;
    logic [`PDR_INT_W-1:0] intStatus;
    logic [`PDR_INT_W-1:0] intMask;
    logic [`PDR_INT_W-1:0] intEvt;
    logic satEvt;
    logic [31:0] rdWord;
    logic rdHit;

    assign regIdx = paddr[ADDR_W-1:2];
    // the transfer completes only at the edge where pready is seen high
    assign access = ce && psel && penable && pready;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign wrTen = wr && (regIdx == `PDR_IDX_TEN);
    assign rdTen = rd && (regIdx == `PDR_IDX_TEN);
    assign wrBist1 = wr && (regIdx == `PDR_IDX_BIST1);
    assign wrBist2 = wr && (regIdx == `PDR_IDX_BIST2);
    assign wrDiag = wr && (regIdx == `PDR_IDX_DIAG);
    assign wrRst = wr && (regIdx == `PDR_IDX_RST);
    assign wrIntSt = wr && (regIdx == `PDR_IDX_INTST);
    assign wrIntMsk = wr && (regIdx == `PDR_IDX_INTMSK);

    // software reset acts as the pin does on every register except swReset itself and the apb answer flops
    assign rstAll = !resetn || swReset; // [R14] [R16]

    ////////////////////////////////////////////////////////////////////////
    // read mux; unlisted bits stay zero

    always_comb begin
        rdWord = 32'h0000_0000;
        rdHit = 1'b1;
        case (regIdx)
            `PDR_IDX_TEN: begin
                rdWord[`PDR_TEN_LOWTH] = lowerRxTh;
                rdWord[`PDR_TEN_SQ_HI:`PDR_TEN_SQ_LO] = squelch;
                rdWord[`PDR_TEN_NLP] = nlpOff;
                rdWord[`PDR_TEN_POL] = polarity;
                rdWord[`PDR_TEN_JAB] = jabOff;
            end
            `PDR_IDX_BIST1: begin
                rdWord[`PDR_B1_ERR_HI:`PDR_B1_ERR_LO] = errLatch; // [R07]
                rdWord[`PDR_B1_IPG_HI:0] = ipgLen;
            end
            `PDR_IDX_BIST2: begin
                rdWord[`PDR_B2_LEN_HI:0] = pktLen;
            end
            `PDR_IDX_DIAG: begin
                rdWord[`PDR_DG_START] = diagStart;
                // quality means nothing without link, so hide it then
                rdWord[`PDR_DG_LQ_HI:`PDR_DG_LQ_LO] =
                    phyEvt.linkUp ? phyEvt.linkQuality : `PDR_LQ_NONE; // [R13]
                rdWord[`PDR_DG_DONE] = diagDoneBit; // [R12]
                rdWord[`PDR_DG_FAIL] = diagFailBit; // [R12]
            end
            `PDR_IDX_RST: begin
                rdWord[`PDR_RC_SWRST] = swReset;
                rdWord[`PDR_RC_RESTART] = restart;
            end
            `PDR_IDX_INTST: begin
                rdWord[`PDR_INT_W-1:0] = intStatus;
            end
            `PDR_IDX_INTMSK: begin
                rdWord[`PDR_INT_W-1:0] = intMask;
            end
            default: begin
                rdHit = 1'b0;
            end
        endcase
    end // [R01]

    ////////////////////////////////////////////////////////////////////////
    // apb answer: one wait-free access phase, data latched at setup

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : rdWord;
                pslverr <= !rdHit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 10 Mb/s controls

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            lowerRxTh <= 1'b0;
            squelch <= `PDR_SQ_RESET;
            nlpOff <= 1'b0;
            jabOff <= 1'b0;
        end else if (ce && wrTen) begin
            lowerRxTh <= pwdata[`PDR_TEN_LOWTH]; // [R02]
            squelch <= pwdata[`PDR_TEN_SQ_HI:`PDR_TEN_SQ_LO]; // [R03]
            nlpOff <= pwdata[`PDR_TEN_NLP]; // [R04]
            jabOff <= pwdata[`PDR_TEN_JAB]; // [R06]
        end
    end

    // a fresh detection in the clearing read's cycle is kept
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            polarity <= 1'b0;
        end else if (ce) begin
            if (phyEvt.polarityInv) begin
                polarity <= 1'b1;
            end else if (rdTen) begin
                polarity <= 1'b0; // [R05]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // self-test error counting and packet settings

    always_comb begin
        next_errCnt = errCnt;
        if (phyEvt.bistByteErr &&
            !(errCnt == `PDR_ERR_MAX && !phyEvt.bistCountMode)) begin
            next_errCnt = 8'(errCnt + 8'h01); // [R07]
        end
    end

    assign satEvt = !phyEvt.bistCountMode && (errCnt != `PDR_ERR_MAX) &&
        (next_errCnt == `PDR_ERR_MAX);

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            errCnt <= 8'h00;
            errLatch <= 8'h00;
        end else if (ce) begin
            if (wrBist1) begin
                errLatch <= errCnt; // [R08]
                // an error landing with the clear still counts once
                if (pwdata[`PDR_B1_LOCKCLR]) begin
                    errCnt <= {7'h00, phyEvt.bistByteErr}; // [R08]
                end else begin
                    errCnt <= next_errCnt;
                end
            end else begin
                errCnt <= next_errCnt;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            ipgLen <= `PDR_IPG_RESET;
            pktLen <= `PDR_PKTLEN_RESET;
        end else if (ce) begin
            if (wrBist1) begin
                ipgLen <= pwdata[`PDR_B1_IPG_HI:0]; // [R09]
            end
            if (wrBist2) begin
                pktLen <= pwdata[`PDR_B2_LEN_HI:0]; // [R10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cable diagnostic handshake

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            diagStart <= 1'b0;
        end else if (ce) begin
            if (wrDiag) begin
                diagStart <= pwdata[`PDR_DG_START]; // [R11]
            end else if (phyEvt.diagDone) begin
                diagStart <= 1'b0; // [R11]
            end
        end
    end

    // a new start clears old results; a result in that cycle wins
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            diagDoneBit <= 1'b0;
            diagFailBit <= 1'b0;
        end else if (ce) begin
            if (phyEvt.diagDone) begin
                diagDoneBit <= 1'b1; // [R12]
            end else if (wrDiag && pwdata[`PDR_DG_START]) begin
                diagDoneBit <= 1'b0;
            end
            if (phyEvt.diagFail) begin
                diagFailBit <= 1'b1; // [R12]
            end else if (wrDiag && pwdata[`PDR_DG_START]) begin
                diagFailBit <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software reset and restart, one-cycle self-clearing pulses

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            swReset <= 1'b0;
        end else if (ce) begin
            swReset <= !swReset && wrRst && pwdata[`PDR_RC_SWRST]; // [R14]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            restart <= 1'b0;
        end else if (ce) begin
            restart <= wrRst && pwdata[`PDR_RC_RESTART]; // [R15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write one to clear, set wins

    always_comb begin
        intEvt = '0;
        intEvt[`PDR_INT_DONE] = phyEvt.diagDone;
        intEvt[`PDR_INT_FAIL] = phyEvt.diagFail;
        intEvt[`PDR_INT_POL] = phyEvt.polarityInv;
        intEvt[`PDR_INT_SAT] = satEvt;
    end

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            intStatus <= '0;
        end else if (ce) begin
            intStatus <= (intStatus &
                ~(wrIntSt ? pwdata[`PDR_INT_W-1:0] : '0)) | intEvt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            intMask <= '0;
        end else if (ce && wrIntMsk) begin
            intMask <= pwdata[`PDR_INT_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(intStatus & intMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all taken from flops

    assign phyCtrl.lowerRxThresholdEn = lowerRxTh;
    assign phyCtrl.squelchLevel = squelch;
    assign phyCtrl.linkPulseTxOff = nlpOff;
    assign phyCtrl.jabberOff = jabOff;
    assign phyCtrl.ipgLength = ipgLen;
    assign phyCtrl.packetLength = pktLen;
    assign phyCtrl.diagStart = diagStart;
    assign phyCtrl.phySoftReset = swReset;
    assign phyCtrl.phyRestart = restart;
    assign polarityMirror = polarity;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_tenRead;
        rdTen;
    endsequence

    sequence s_swResetWrite;
        wrRst && pwdata[`PDR_RC_SWRST] && !swReset;
    endsequence

    sequence s_diagFinish;
        ce && phyEvt.diagDone && !wrDiag;
    endsequence

    a_rsvd_read_zero: assert property ( // [R01]
        s_tenRead |-> (prdata[15:0] & ~(`PDR_TEN_RW_MASK |
            (16'h0001 << `PDR_TEN_POL))) == 16'h0000 &&
            prdata[31:16] == 16'h0000)
        else $error("reserved bits read nonzero");

    a_thresh_write: assert property ( // [R02]
        wrTen |=> lowerRxTh == $past(pwdata[`PDR_TEN_LOWTH]))
        else $error("threshold bit did not follow write");

    a_squelch_write: assert property ( // [R03]
        wrTen |=> squelch == $past(pwdata[`PDR_TEN_SQ_HI:`PDR_TEN_SQ_LO]))
        else $error("squelch field did not follow write");

    a_polarity_clear: assert property ( // [R05]
        s_tenRead ##0 !phyEvt.polarityInv |=> !polarityMirror)
        else $error("polarity flag not cleared by read");

    a_errcnt_sat: assert property ( // [R07]
        ce && !phyEvt.bistCountMode && errCnt == `PDR_ERR_MAX &&
            !wrBist1 && !swReset |=> errCnt == `PDR_ERR_MAX)
        else $error("error counter wrapped in saturate mode");

    a_err_freeze: assert property ( // [R08]
        wrBist1 |=> errLatch == $past(errCnt))
        else $error("error count not frozen on write");

    a_start_clear: assert property ( // [R11]
        s_diagFinish |=> !diagStart && diagDoneBit)
        else $error("start bit not cleared with done");

    a_swreset_seq: assert property ( // [R14]
        s_swResetWrite |=> swReset ##1 (!swReset &&
            ipgLen == `PDR_IPG_RESET && pktLen == `PDR_PKTLEN_RESET &&
            squelch == `PDR_SQ_RESET && !diagStart)) // [R16]
        else $error("software reset did not restore defaults");

    a_restart_pulse: assert property ( // [R15]
        wrRst && pwdata[`PDR_RC_RESTART] && !swReset |=>
            restart ##1 (!ce || !restart))
        else $error("restart bit not self-clearing");

endmodule : pdr_regs

/* File: verification/pdr_regs_tb.sv */
`include "pdr_consts.svh"

module pdr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pdr_pkg::*;

    localparam pdr_evt_t EV_POL = 8'h80;
    localparam pdr_evt_t EV_ERR = 8'h40;
    localparam pdr_evt_t EV_DONE = 8'h10;
    localparam pdr_evt_t EV_FAIL = 8'h08;

    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic polarityMirror;
    logic irq;
    pdr_evt_t evt = 8'h00;
    pdr_ctrl_t ctrl;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int swRstCnt = 0;
    int restartCnt = 0;
    logic [31:0] rd;
    logic err;

    always #2.5 core_clk = ~core_clk;

    pdr_regs i_pdr_regs (
        .core_clk(core_clk), .resetn(resetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .phyEvt(evt), .phyCtrl(ctrl),
        .polarityMirror(polarityMirror), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////
    // watchdog and pulse counting
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (ctrl.phySoftReset === 1'b1) swRstCnt <= swRstCnt + 1;
        if (ctrl.phyRestart === 1'b1) restartCnt <= restartCnt + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string n, input logic [31:0] seen,
            input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [5:0] idx,
            input logic [15:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // effects of the access edge land by nba; let them settle
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rdchk(input string n, input logic [5:0] idx,
            input logic [15:0] e);
        apb(1'b0, idx, 16'h0000);
        chk(n, rd, {16'h0000, e});
        chk("slverr", 32'(err), 32'h0);
    endtask : rdchk

    task automatic pulse(input pdr_evt_t m, input int n);
        @(posedge core_clk);
        evt <= evt | m;
        repeat (n) @(posedge core_clk);
        evt <= evt & ~m;
        repeat (2) @(posedge core_clk);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        rdchk("ten", `PDR_IDX_TEN, 16'h0000);
        rdchk("bist1", `PDR_IDX_BIST1, 16'h007d);
        rdchk("bist2", `PDR_IDX_BIST2, 16'h05dc);
        rdchk("diag", `PDR_IDX_DIAG, 16'h0000);
        rdchk("rst", `PDR_IDX_RST, 16'h0000);
    endtask : t_defaults

    task automatic t_fields();
        wr(`PDR_IDX_TEN, 16'hffff);
        rdchk("ten rw", `PDR_IDX_TEN, 16'h3e81);
        chk("lowth", 32'(ctrl.lowerRxThresholdEn), 32'h1);
        chk("nlp", 32'(ctrl.linkPulseTxOff), 32'h1);
        chk("jab", 32'(ctrl.jabberOff), 32'h1);
        // every level from 200mV to 600mV
        for (int i = 0; i <= 8; i++) begin
            wr(`PDR_IDX_TEN, 16'(i << 9));
            chk("squelch", 32'(ctrl.squelchLevel), 32'(i));
        end
        wr(`PDR_IDX_BIST2, 16'hffff);
        rdchk("bist2 rw", `PDR_IDX_BIST2, 16'h07ff);
        chk("pktlen", 32'(ctrl.packetLength), 32'h7ff);
        wr(`PDR_IDX_BIST1, 16'h0003);
        chk("ipg", 32'(ctrl.ipgLength), 32'h3);
        apb(1'b0, 6'h1d, 16'h0000);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
    endtask : t_fields

    task automatic t_polarity();
        wr(`PDR_IDX_TEN, 16'h0000);
        wr(`PDR_IDX_INTMSK, 16'h0004);
        pulse(EV_POL, 1);
        chk("mirror", 32'(polarityMirror), 32'h1);
        chk("irq pol", 32'(irq), 32'h1);
        rdchk("pol set", `PDR_IDX_TEN, 16'h0010);
        rdchk("pol clr", `PDR_IDX_TEN, 16'h0000);
        chk("mirror clr", 32'(polarityMirror), 32'h0);
        rdchk("intst", `PDR_IDX_INTST, 16'h0004);
        wr(`PDR_IDX_INTST, 16'h0004);
        wr(`PDR_IDX_INTMSK, 16'h0000);
        pulse(EV_POL, 1);
        chk("irq masked", 32'(irq), 32'h0);
        rdchk("intst masked", `PDR_IDX_INTST, 16'h0004);
        wr(`PDR_IDX_INTST, 16'h000f);
        rdchk("intst w1c", `PDR_IDX_INTST, 16'h0000);
        // second detection must be read away before later tests
        rdchk("pol again", `PDR_IDX_TEN, 16'h0010);
    endtask : t_polarity

    task automatic t_errors();
        wr(`PDR_IDX_BIST1, 16'h807d);
        pulse(EV_ERR, 300);
        wr(`PDR_IDX_BIST1, 16'h807d);
        rdchk("err sat", `PDR_IDX_BIST1, 16'hff7d);
        rdchk("sat int", `PDR_IDX_INTST, 16'h0008);
        wr(`PDR_IDX_INTST, 16'h0008);
        pulse(EV_ERR, 5);
        rdchk("err frozen", `PDR_IDX_BIST1, 16'hff7d);
        wr(`PDR_IDX_BIST1, 16'h007d);
        rdchk("err after clr", `PDR_IDX_BIST1, 16'h057d);
        wr(`PDR_IDX_BIST1, 16'h807d);
        evt.bistCountMode <= 1'b1;
        pulse(EV_ERR, 258);
        wr(`PDR_IDX_BIST1, 16'h007d);
        rdchk("err wrap", `PDR_IDX_BIST1, 16'h027d);
        evt.bistCountMode <= 1'b0;
        // errors arriving while the enable is low must not count
        wr(`PDR_IDX_BIST1, 16'h807d);
        ce <= 1'b0;
        pulse(EV_ERR, 3);
        ce <= 1'b1;
        wr(`PDR_IDX_BIST1, 16'h007d);
        rdchk("ce frozen", `PDR_IDX_BIST1, 16'h007d);
    endtask : t_errors

    task automatic t_diag();
        wr(`PDR_IDX_INTMSK, 16'h0003);
        wr(`PDR_IDX_DIAG, 16'h8000);
        chk("start", 32'(ctrl.diagStart), 32'h1);
        rdchk("diag run", `PDR_IDX_DIAG, 16'h8000);
        pulse(EV_DONE, 1);
        chk("start clr", 32'(ctrl.diagStart), 32'h0);
        chk("irq done", 32'(irq), 32'h1);
        evt.linkUp <= 1'b1;
        for (int q = 1; q <= 3; q++) begin
            evt.linkQuality <= 2'(q);
            rdchk("quality", `PDR_IDX_DIAG, 16'(q << 8) | 16'h0002);
        end
        evt.linkUp <= 1'b0;
        rdchk("quality down", `PDR_IDX_DIAG, 16'h0002);
        wr(`PDR_IDX_DIAG, 16'h8000);
        pulse(EV_FAIL, 1);
        rdchk("diag fail", `PDR_IDX_DIAG, 16'h8001);
        rdchk("diag int", `PDR_IDX_INTST, 16'h0003);
        wr(`PDR_IDX_INTST, 16'h0003);
        repeat (2) @(posedge core_clk);
        chk("irq clr", 32'(irq), 32'h0);
    endtask : t_diag

    task automatic t_resets();
        wr(`PDR_IDX_TEN, 16'h2081);
        wr(`PDR_IDX_RST, 16'h4000);
        repeat (2) @(posedge core_clk);
        chk("restart pulse", 32'(restartCnt), 32'h1);
        rdchk("restart sc", `PDR_IDX_RST, 16'h0000);
        rdchk("restart keep", `PDR_IDX_TEN, 16'h2081);
        wr(`PDR_IDX_RST, 16'h8000);
        repeat (2) @(posedge core_clk);
        chk("swrst pulse", 32'(swRstCnt), 32'h1);
        rdchk("swrst sc", `PDR_IDX_RST, 16'h0000);
        rdchk("swrst ten", `PDR_IDX_TEN, 16'h0000);
        rdchk("swrst bist1", `PDR_IDX_BIST1, 16'h007d);
        rdchk("swrst bist2", `PDR_IDX_BIST2, 16'h05dc);
        rdchk("swrst diag", `PDR_IDX_DIAG, 16'h0000);
        chk("swrst start", 32'(ctrl.diagStart), 32'h0);
    endtask : t_resets

    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        t_defaults();
        t_fields();
        t_polarity();
        t_errors();
        t_diag();
        t_resets();
        final_report();
    end

endmodule : pdr_regs_tb
